// ===== gscr_pkg.sv
// package: layouts, offsets and reset values of the global control bank
package gscr_pkg;

	// ==============================================================
	// register offsets (byte addresses on the register bus)
	localparam logic [11:0] SYSCTRL_OFS = 12'h000;
	localparam logic [11:0] RST0_OFS    = 12'h004;
	localparam logic [11:0] CLKCTRL_OFS = 12'h008;
	localparam logic [11:0] PM_OFS      = 12'h00c;

	// ==============================================================
	// reset values and masks
	localparam logic [31:0] SYSCTRL_RST = 32'h0000_1002;
	localparam logic [31:0] RST0_RST    = 32'h0000_0000;
	localparam logic [31:0] CLKCTRL_RST = 32'h4008_0808;
	localparam logic [31:0] PM_RST      = 32'h0003_1000;
	// implemented reset request bits
	localparam logic [31:0] RST0_MASK   = 32'hf101_f9ef;

	// ==============================================================
	// field layouts, msb first
	typedef struct packed {
		logic [15:0] rsv_hi;
		logic        chk_fail;
		logic        swd_en;
		logic        chk_start;
		logic        rom_done;
		logic [4:0]  dnm;
		logic        flush;
		logic        fpu_dis;
		logic [1:0]  rsv_mid;
		logic [1:0]  arb;
		logic        rsv_lo;
	} gscr_sysctrl_t;

	typedef struct packed {
		logic       ext_rdy;
		logic       rsv30;
		logic       nano_rdy;
		logic       baud_rdy;
		logic       prim_rdy;
		logic       rsv26;
		logic       rtc_rdy;
		logic       hf_rdy;
		logic [1:0] rsv_hi;
		logic       baud_osc_supply_select;
		logic       baud_en;
		logic       prim_en;
		logic       dnm18;
		logic       rtc_en;
		logic       hf_en;
		logic [1:0] prim_div;
		logic       sw_rdy;
		logic       rsv12;
		logic [2:0] osc_sel;
		logic [2:0] sys_div;
		logic [5:0] dnm;
	} gscr_clkctrl_t;

	typedef struct packed {
		logic [10:0] rsv_hi;
		logic        crystal_bypass;
		logic [1:0]  dnm_a;
		logic        baud_osc_power_down;
		logic        primary_osc_power_down;
		logic [2:0]  dnm_b;
		logic        hf_crystal_power_down;
		logic [2:0]  dnm_c;
		logic        lp_serial_wake_enable;
		logic        lp_timer1_wake_enable;
		logic        lp_timer0_wake_enable;
		logic [5:0]  rsv_lo;
	} gscr_pm_t;

	// ==============================================================
	// carriers
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} gscr_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} gscr_apb_rsp_t;

	// one bit per clock source
	typedef struct packed {
		logic ext;
		logic nano;
		logic baud;
		logic prim;
		logic rtc;
		logic hf;
	} gscr_osc_t;

	typedef struct packed {
		logic       chk_done;
		logic       chk_fail;
		logic       flush_done;
		logic       debug_lock;
		logic       deep_sleep;
		logic [2:0] wake_evt;
	} gscr_evt_t;

	typedef struct packed {
		logic        swd_en;
		logic        fpu_dis;
		logic [1:0]  arb;
		logic        chk_req;
		logic        flush_req;
		logic [31:0] rst_req;
		logic        hf_en;
		logic        rtc_en;
		logic        prim_en;
		logic        baud_en;
		logic        baud_pd;
		logic        prim_pd;
		logic        hf_pd;
		logic        crystal_bypass;
		logic        baud_supply;
		logic        sys_clk_en;
		logic        sw_rdy;
		logic        wake_req;
	} gscr_ctrl_t;

	// whole state of the bank except crystal bypass, which is kept in its own flop
	typedef struct packed {
		gscr_sysctrl_t sc;
		logic [31:0]   rst;
		gscr_clkctrl_t ck;
		gscr_pm_t      pm;
		logic [2:0]    prim_cnt;
		logic [6:0]    sys_cnt;
		gscr_apb_rsp_t rsp;
		logic          sys_clk_en;
		logic          baud_supply;
		logic          wake_req;
	} gscr_state_t;

endpackage : gscr_pkg

// ===== gscr_regs.sv
// file: global system control register bank with apb slave
`timescale 1ns/10ps

// Summary of operation
// - checksum result bit: 0 pass, 1 fail, valid once start bit clears
// - writing 1 starts checksum; hardware clears it and posts result
// - debug port bit enables debug; writable only while lock is clear
// - writing 1 flushes caches; bit reads 1 until flush completes
// - floating point disable bit, 1 disables, resets to 0
// - arbitration field: 0 fixed burst, 1 round robin, reset 1
// - reset request bits set by writing 1, cleared when reset done
// - peripheral reset leaves this bank and always-on logic alone
// - ready flags read 1 only when source is ready and, where it has an enable, enabled
// - oscillator enables; primary resets on, others reset off
// - baud supply select restored automatically on deep sleep exit
// - primary oscillator prescaled by 1, 2, 4 or 8
// - oscillator select field, reset 4, picks system oscillator
// - changing oscillator select clears switch ready until done
// - system prescaler divides selected oscillator, resets to 0
// - crystal bypass cleared only by power-on reset
// - wake enables let low-power serial and timers wake device
// - only system or power-on reset clears this bank
module gscr_regs
	import gscr_pkg::*;
(
	// clock and resets
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          por_n,
	// register bus
	input  wire gscr_apb_req_t apb_req,
	output gscr_apb_rsp_t      apb_rsp,
	// clock sources: ready levels and tick enables
	input  wire gscr_osc_t     osc_rdy,
	input  wire gscr_osc_t     osc_tick,
	// completion and status events
	input  wire gscr_evt_t     evt,
	input  wire logic [31:0]   rst_done,
	// control outputs
	output gscr_ctrl_t         ctrl
);

	// ==============================================================
	// state and decode signals
	gscr_state_t   q;
	gscr_state_t   d;
	logic          bypass_q;
	logic          apb_wr;
	logic          wr_sc;
	logic          wr_rs;
	logic          wr_ck;
	logic          wr_pm;
	gscr_sysctrl_t wsc;
	gscr_clkctrl_t wck;
	gscr_pm_t      wpm;
	gscr_sysctrl_t sc_rd;
	gscr_clkctrl_t ck_rd;
	gscr_pm_t      pm_rd;
	logic [7:0]    rdy_v;
	logic [7:0]    tick_v;
	logic [2:0]    prim_mask;
	logic [6:0]    sys_mask;
	logic          prim_tick;
	logic          sys_tick;

	// ==============================================================
	// next state
	always_comb begin
		d = q;
		// access phase with ready high is the one commit edge
		apb_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
			&& q.rsp.pready;
		wsc = gscr_sysctrl_t'(apb_req.pwdata);
		wck = gscr_clkctrl_t'(apb_req.pwdata);
		wpm = gscr_pm_t'(apb_req.pwdata);
		wr_sc = apb_wr && (apb_req.paddr == SYSCTRL_OFS);
		wr_rs = apb_wr && (apb_req.paddr == RST0_OFS);
		wr_ck = apb_wr && (apb_req.paddr == CLKCTRL_OFS);
		wr_pm = apb_wr && (apb_req.paddr == PM_OFS);

		// ready flags read low while the source is off
		rdy_v = {osc_rdy.ext, osc_rdy.rtc && q.ck.rtc_en,
			osc_rdy.baud && q.ck.baud_en,
			osc_rdy.prim && q.ck.prim_en, osc_rdy.nano,
			osc_rdy.hf && q.ck.hf_en, 2'b00};

		// read views with live fields laid over stored bits
		sc_rd = q.sc;
		sc_rd.rom_done = 1'b1;
		ck_rd = q.ck;
		ck_rd.ext_rdy = rdy_v[7];
		ck_rd.rtc_rdy = rdy_v[6];
		ck_rd.baud_rdy = rdy_v[5];
		ck_rd.prim_rdy = rdy_v[4];
		ck_rd.nano_rdy = rdy_v[3];
		ck_rd.hf_rdy = rdy_v[2];
		pm_rd = q.pm;
		pm_rd.crystal_bypass = bypass_q;

		// read data is latched in setup so the access phase is free
		d.rsp.pready = apb_req.psel && !apb_req.penable;
		if (apb_req.psel && !apb_req.penable) begin
			d.rsp.pslverr = 1'b0;
			case (apb_req.paddr)
				SYSCTRL_OFS: d.rsp.prdata = sc_rd;
				RST0_OFS:    d.rsp.prdata = q.rst;
				CLKCTRL_OFS: d.rsp.prdata = ck_rd;
				PM_OFS:      d.rsp.prdata = pm_rd;
				default: begin
					d.rsp.prdata = 32'h0000_0000;
					d.rsp.pslverr = 1'b1;
				end
			endcase
		end

		// system control plain fields
		if (wr_sc) begin
			d.sc.dnm = wsc.dnm;
			d.sc.fpu_dis = wsc.fpu_dis;
			d.sc.arb = wsc.arb;
			if (!evt.debug_lock) begin
				d.sc.swd_en = wsc.swd_en;
			end
		end

		// checksum: completion clears, a fresh start wins the tie
		if (q.sc.chk_start && evt.chk_done) begin
			d.sc.chk_start = 1'b0;
			d.sc.chk_fail = evt.chk_fail;
		end
		if (wr_sc && wsc.chk_start) begin
			d.sc.chk_start = 1'b1;
		end

		// cache flush, same set-over-clear shape
		if (q.sc.flush && evt.flush_done) begin
			d.sc.flush = 1'b0;
		end
		if (wr_sc && wsc.flush) begin
			d.sc.flush = 1'b1;
		end

		// reset requests: done clears, a write of 1 sets and wins
		d.rst = (q.rst & ~rst_done)
			| (wr_rs ? (apb_req.pwdata & RST0_MASK) : 32'h0);

		// clock control writable fields
		if (wr_ck) begin
			d.ck.baud_osc_supply_select = wck.baud_osc_supply_select;
			d.ck.baud_en = wck.baud_en;
			d.ck.prim_en = wck.prim_en;
			d.ck.rtc_en = wck.rtc_en;
			d.ck.hf_en = wck.hf_en;
			d.ck.dnm18 = wck.dnm18;
			d.ck.prim_div = wck.prim_div;
			d.ck.osc_sel = wck.osc_sel;
			d.ck.sys_div = wck.sys_div;
			d.ck.dnm = wck.dnm;
		end

		// switch ready: drops on a changed select, rises when the
		// new source reports ready; reserved codes never become ready
		if (wr_ck && (wck.osc_sel != q.ck.osc_sel)) begin
			d.ck.sw_rdy = 1'b0;
		end else if (!q.ck.sw_rdy && rdy_v[q.ck.osc_sel]) begin
			d.ck.sw_rdy = 1'b1;
		end

		// power management writable fields
		if (wr_pm) begin
			d.pm.dnm_a = wpm.dnm_a;
			d.pm.dnm_b = wpm.dnm_b;
			d.pm.dnm_c = wpm.dnm_c;
			d.pm.baud_osc_power_down = wpm.baud_osc_power_down;
			d.pm.primary_osc_power_down = wpm.primary_osc_power_down;
			d.pm.hf_crystal_power_down = wpm.hf_crystal_power_down;
			d.pm.lp_serial_wake_enable = wpm.lp_serial_wake_enable;
			d.pm.lp_timer1_wake_enable = wpm.lp_timer1_wake_enable;
			d.pm.lp_timer0_wake_enable = wpm.lp_timer0_wake_enable;
		end

		// primary prescaler, 2^n ticks per output tick; the >= compare
		// recovers at once when the divide is shrunk mid-count
		prim_mask = 3'((4'h1 << q.ck.prim_div) - 4'h1);
		prim_tick = osc_tick.prim && (q.prim_cnt >= prim_mask);
		if (osc_tick.prim) begin
			d.prim_cnt = prim_tick ? 3'h0 : 3'(q.prim_cnt + 3'h1);
		end

		// selected source drives the system prescaler
		tick_v = {osc_tick.ext, osc_tick.rtc, osc_tick.baud, prim_tick,
			osc_tick.nano, osc_tick.hf, 2'b00};
		sys_tick = tick_v[q.ck.osc_sel] && rdy_v[q.ck.osc_sel];
		sys_mask = 7'((8'h1 << q.ck.sys_div) - 8'h1);
		d.sys_clk_en = sys_tick && (q.sys_cnt >= sys_mask);
		if (sys_tick) begin
			d.sys_cnt = d.sys_clk_en ? 7'h00 : 7'(q.sys_cnt + 7'h01);
		end

		// regulator supply while asleep, chosen supply once awake
		d.baud_supply = evt.deep_sleep ? 1'b0
			: q.ck.baud_osc_supply_select;

		// wake request only from enabled low-power sources
		d.wake_req = |(evt.wake_evt & {q.pm.lp_serial_wake_enable,
			q.pm.lp_timer1_wake_enable,
			q.pm.lp_timer0_wake_enable});
	end

	// ==============================================================
	// state register; only system reset reaches it, the soft and
	// peripheral reset requests never loop back here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.sc <= gscr_sysctrl_t'(SYSCTRL_RST);
			q.rst <= RST0_RST;
			q.ck <= gscr_clkctrl_t'(CLKCTRL_RST);
			q.pm <= gscr_pm_t'(PM_RST);
		end else begin
			q <= d;
		end
	end

	// crystal bypass lives apart: only power-on reset clears it
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			bypass_q <= 1'b0;
		end else if (wr_pm) begin
			bypass_q <= wpm.crystal_bypass;
		end
	end

	// ==============================================================
	// outputs, all straight from flops
	assign apb_rsp = q.rsp;
	assign ctrl.swd_en = q.sc.swd_en;
	assign ctrl.fpu_dis = q.sc.fpu_dis;
	assign ctrl.arb = q.sc.arb;
	assign ctrl.chk_req = q.sc.chk_start;
	assign ctrl.flush_req = q.sc.flush;
	assign ctrl.rst_req = q.rst;
	assign ctrl.hf_en = q.ck.hf_en;
	assign ctrl.rtc_en = q.ck.rtc_en;
	assign ctrl.prim_en = q.ck.prim_en;
	assign ctrl.baud_en = q.ck.baud_en;
	assign ctrl.baud_pd = q.pm.baud_osc_power_down;
	assign ctrl.prim_pd = q.pm.primary_osc_power_down;
	assign ctrl.hf_pd = q.pm.hf_crystal_power_down;
	assign ctrl.crystal_bypass = bypass_q;
	assign ctrl.baud_supply = q.baud_supply;
	assign ctrl.sys_clk_en = q.sys_clk_en;
	assign ctrl.sw_rdy = q.ck.sw_rdy;
	assign ctrl.wake_req = q.wake_req;

	// ==============================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cksum_start: assert property (wr_sc && wsc.chk_start
		|=> ctrl.chk_req)
		else $error("checksum start not taken");
	a_cksum_result: assert property (ctrl.chk_req && evt.chk_done
		&& !(wr_sc && wsc.chk_start) |=> !ctrl.chk_req
		&& (q.sc.chk_fail == $past(evt.chk_fail)))
		else $error("checksum result not posted");
	a_debug_lock: assert property (evt.debug_lock
		|=> $stable(ctrl.swd_en))
		else $error("debug bit changed while locked");
	a_flush_busy: assert property (ctrl.flush_req && !evt.flush_done
		|=> ctrl.flush_req)
		else $error("flush bit dropped before completion");
	a_rst_hold: assert property (!wr_rs && (rst_done == 32'h0)
		|=> $stable(ctrl.rst_req))
		else $error("reset request changed without cause");
	a_sel_clear: assert property (wr_ck && (wck.osc_sel != q.ck.osc_sel)
		|=> !ctrl.sw_rdy)
		else $error("switch ready not cleared on select change");
	a_sys_div1: assert property (q.ck.sys_div == 3'h0 && sys_tick
		|=> ctrl.sys_clk_en)
		else $error("undivided system tick missing");
	a_supply_back: assert property (!evt.deep_sleep ##1 !evt.deep_sleep
		|=> ctrl.baud_supply == $past(q.ck.baud_osc_supply_select))
		else $error("baud supply not restored");
	a_wake_gate: assert property (!ctrl.wake_req |->
		$past(evt.wake_evt & {q.pm.lp_serial_wake_enable,
		q.pm.lp_timer1_wake_enable, q.pm.lp_timer0_wake_enable})
		== 3'h0)
		else $error("enabled wake event lost");
	a_bus_ready: assert property (apb_req.psel && !apb_req.penable
		|=> apb_rsp.pready ##1 !apb_rsp.pready)
		else $error("bus ready not one cycle after setup");

endmodule : gscr_regs

// ===== gscr_regs_tb_top.sv
// self-checking testbench for the global control register bank
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	miscompares++; $display("Error %0t: got %h exp %h", $time, a, b); end end

module gscr_regs_tb_top
	import gscr_pkg::*;
;
	// ==========
	// signals
	logic          clk;
	logic          rst_n;
	logic          por_n;
	gscr_apb_req_t apb_req;
	gscr_apb_rsp_t apb_rsp;
	gscr_osc_t     osc_rdy;
	gscr_osc_t     osc_tick;
	gscr_evt_t     evt;
	logic [31:0]   rst_done;
	logic [31:0]   r;
	gscr_ctrl_t    ctrl;
	logic [32:0]   exp_q[$];
	int            miscompares;
	int            samples_checked;
	int            pulses;
	int            n;

	gscr_regs dut_u (
		.clk(clk), .rst_n(rst_n), .por_n(por_n),
		.apb_req(apb_req), .apb_rsp(apb_rsp),
		.osc_rdy(osc_rdy), .osc_tick(osc_tick),
		.evt(evt), .rst_done(rst_done), .ctrl(ctrl));

	// 25 mhz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ==========
	// closing report
	task automatic end_sim;
		$display("miscompares=%0d samples_checked=%0d", miscompares,
			samples_checked);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_sim

	// ==========
	// apb master: note expectation, then hold request until pready
	task automatic apb(input logic we, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e);
		int k;
		exp_q.push_back(e);
		@(posedge clk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: we, paddr: a,
			pwdata: d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (apb_rsp.pready !== 1'b1 && k < 20);
		apb_req <= '0;
		if (k >= 20) begin
			miscompares++;
			end_sim();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask : rd

	// let edge updates land before looking at levels
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	// ==========
	// response watcher, oldest note first
	always @(posedge clk) begin : watch
		logic [32:0] e;
		if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
			e = exp_q.pop_front();
			if (apb_req.pwrite)
				`CHK(apb_rsp.pslverr, e[32])
			else
				`CHK({apb_rsp.pslverr, apb_rsp.prdata}, e)
		end
	end

	// system clock enable pulses, counted for the prescaler check
	always @(posedge clk) begin
		if (ctrl.sys_clk_en === 1'b1)
			pulses <= pulses + 1;
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_sim();
	end

	// ==========
	// main sequence
	initial begin
		rst_n = 1'b0;
		por_n = 1'b0;
		apb_req = '0;
		osc_rdy = '1;
		osc_tick = '0;
		evt = '0;
		rst_done = '0;
		miscompares = 0;
		samples_checked = 0;
		pulses = 0;
		void'($urandom(10));
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		// reset values, unmapped places refused
		rd(SYSCTRL_OFS, SYSCTRL_RST);
		rd(RST0_OFS, RST0_RST);
		rd(CLKCTRL_OFS, 32'he808_2808);
		rd(PM_OFS, PM_RST);
		`CHK({ctrl.baud_en, ctrl.prim_en, ctrl.rtc_en, ctrl.hf_en}, 4'b0100)
		apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
		apb(1'b1, 12'h014, '1, {1'b1, 32'h0});
		// checksum with debug bit locked
		evt.debug_lock <= 1'b1;
		wr(SYSCTRL_OFS, 32'h0000_6020);
		tick(2);
		`CHK(ctrl.chk_req, 1'b1)
		`CHK(ctrl.swd_en, 1'b0)
		`CHK(ctrl.fpu_dis, 1'b1)
		`CHK(ctrl.arb, 2'b00)
		@(posedge clk);
		evt.chk_done <= 1'b1;
		evt.chk_fail <= 1'b1;
		@(posedge clk);
		evt.chk_done <= 1'b0;
		evt.debug_lock <= 1'b0;
		rd(SYSCTRL_OFS, 32'h0000_9020);
		// flush busy, a zero written meanwhile does nothing
		wr(SYSCTRL_OFS, 32'h0000_4042);
		wr(SYSCTRL_OFS, 32'h0000_4002);
		rd(SYSCTRL_OFS, 32'h0000_d042);
		tick(1);
		`CHK(ctrl.flush_req, 1'b1)
		@(posedge clk);
		evt.flush_done <= 1'b1;
		@(posedge clk);
		evt.flush_done <= 1'b0;
		rd(SYSCTRL_OFS, 32'h0000_d002);
		// reset requests, all cleared by completions
		r = $urandom;
		wr(RST0_OFS, r);
		rd(RST0_OFS, r & RST0_MASK);
		`CHK(ctrl.rst_req, r & RST0_MASK)
		rst_done <= '1;
		@(posedge clk);
		rst_done <= '0;
		rd(RST0_OFS, 32'h0);
		rd(SYSCTRL_OFS, 32'h0000_d002);
		// power management fields and wake gating
		r = $urandom | 32'h0010_0000;
		wr(PM_OFS, r);
		rd(PM_OFS, r & 32'h001f_ffc0);
		`CHK({ctrl.baud_pd, ctrl.prim_pd, ctrl.hf_pd}, {r[17:16], r[12]})
		for (int i = 0; i < 3; i++) begin
			wr(PM_OFS, PM_RST | (32'h40 << i) | 32'h0010_0000);
			for (int j = 0; j < 3; j++) begin
				@(posedge clk);
				evt.wake_evt <= 3'b001 << j;
				@(posedge clk);
				evt.wake_evt <= 3'b000;
				#1;
				`CHK(ctrl.wake_req, i == j)
			end
		end
		// system reset keeps bypass, power-on reset clears it
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(PM_OFS, PM_RST | 32'h0010_0000);
		rd(SYSCTRL_OFS, SYSCTRL_RST);
		`CHK(ctrl.crystal_bypass, 1'b1)
		por_n <= 1'b0;
		@(posedge clk);
		por_n <= 1'b1;
		tick(1);
		`CHK(ctrl.crystal_bypass, 1'b0)
		// switch to a source that is not yet ready
		@(posedge clk);
		osc_rdy.nano <= 1'b0;
		wr(CLKCTRL_OFS, 32'h4028_0648);
		tick(2);
		`CHK(ctrl.sw_rdy, 1'b0)
		`CHK(ctrl.baud_supply, 1'b1)
		rd(CLKCTRL_OFS, 32'hc828_0648);
		osc_rdy.nano <= 1'b1;
		n = 0;
		while (ctrl.sw_rdy !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20) begin
			miscompares++;
			end_sim();
		end
		rd(CLKCTRL_OFS, 32'he828_2648);
		// deep sleep forces the dedicated supply
		evt.deep_sleep <= 1'b1;
		tick(2);
		`CHK(ctrl.baud_supply, 1'b0)
		@(posedge clk);
		evt.deep_sleep <= 1'b0;
		tick(2);
		`CHK(ctrl.baud_supply, 1'b1)
		// divide by two: forty source ticks give twenty pulses
		@(posedge clk);
		n = pulses;
		osc_tick.nano <= 1'b1;
		repeat (40) @(posedge clk);
		osc_tick.nano <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(pulses - n, 20)
		// primary halved, system undivided: eight ticks give four pulses
		wr(CLKCTRL_OFS, 32'h4028_4808);
		@(posedge clk);
		n = pulses;
		osc_tick.prim <= 1'b1;
		repeat (8) @(posedge clk);
		osc_tick.prim <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(pulses - n, 4)
		end_sim();
	end

endmodule : gscr_regs_tb_top
